// File: dsc_config_monitor.sv
// Purpose: Port-level checks of the configuration bank
// Assumes: ce stays high while the bus is active
// Notes:   Lock state is shadowed from lock-word writes
`timescale 1ns/100ps
module dsc_config_monitor (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  ce,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [10:0]           wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire dsc_pkg::dsc_fwd_req_t fwd_req,
  input wire logic                  fwd_ack,
  input wire logic [31:0]           fwd_rdata,
  input wire logic                  pll_lock,
  input wire dsc_pkg::dsc_pll_cfg_t pll_cfg,
  input wire logic                  ctrl_clk_en
);
  logic lock_q;
  wire  take = ce && wb_cyc_i && wb_stb_i && !wb_ack_o && !fwd_req.valid;
  wire  dsc_pkg::dsc_region_t rgn = (wb_adr_i[10:9] == 2'b00) ? dsc_pkg::RGN_CTRL :
                                    (wb_adr_i[10:9] == 2'b01) ? dsc_pkg::RGN_PHY :
                                    dsc_pkg::RGN_FIC;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // The lock word is never locked
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) lock_q <= 1'b0;
    else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == dsc_pkg::OFS_WR_LOCK)
      lock_q <= wb_dat_i[0];
  sequence s_take;
    take;
  endsequence
  sequence s_clk_wr;
    take && wb_we_i && wb_sel_i[0] && wb_adr_i == dsc_pkg::OFS_CLK_EN;
  endsequence
  a_sys_ack_next:
    assert property (s_take ##0 (wb_adr_i >= dsc_pkg::SYS_LO) |=> wb_ack_o)
    else $error("sys ack late");
  a_fwd_region_addr:
    assert property (s_take ##0 (wb_adr_i < dsc_pkg::SYS_LO) |=> fwd_req.valid &&
      fwd_req.addr == $past(wb_adr_i) && fwd_req.region == $past(rgn))
    else $error("fwd req bad");
  a_fwd_wait_hold:
    assert property (fwd_req.valid && !fwd_ack |=> fwd_req.valid && $stable(fwd_req) && !wb_ack_o)
    else $error("fwd req moved");
  a_fwd_done_data:
    assert property (fwd_req.valid && fwd_ack && !fwd_req.we |=> !fwd_req.valid && wb_ack_o &&
      wb_dat_o == $past(fwd_rdata))
    else $error("fwd answer bad");
  a_ack_one_cycle:
    assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack too long");
  a_write_no_data:
    assert property (wb_ack_o && wb_we_i && wb_adr_i >= dsc_pkg::SYS_LO |-> wb_dat_o == 32'h0000_0000)
    else $error("write data nonzero");
  a_lock_live_read:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i == dsc_pkg::OFS_LOCK_A |->
      wb_dat_o == {31'h0000_0000, $past(pll_lock, 2)})
    else $error("lock read bad");
  a_clk_gate_write:
    assert property (s_clk_wr |-> ##2 ctrl_clk_en ==
      (lock_q ? $past(ctrl_clk_en, 2) : $past(wb_dat_i[0], 2)))
    else $error("clk gate bad");
  a_bypass_wins:
    assert property (pll_cfg.bypass |-> !pll_cfg.reset && pll_cfg.power_down)
    else $error("bypass loses");
  a_post_div_code:
    assert property ($onehot0(pll_cfg.post_div_ratio))
    else $error("post div bad");
endmodule
bind dsc_config_regs dsc_config_monitor i_mon (.ref_clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fwd_req, .fwd_ack,
  .fwd_rdata, .pll_lock, .pll_cfg, .ctrl_clk_en);

// File: dsc_config_regs.sv
// What this block does
// - 0x000-0x1FC is the memory controller region.
// - 0x200-0x3FC is the physical layer region.
// - 0x400-0x4FC is the memory fabric interface region.
// - 0x500-0x5FC is the system register group; 0x600-0x7FC is reserved.
// - While locked, writes leave the system register group unchanged except the lock word at 0x5F8.
// - Words 0x500, 0x504, 0x508 drive the fabric PLL configuration inputs.
// - Word 0x50C gates the memory controller clock.
// - Word 0x510 selects the standby glitch-free clock multiplexers.
// - Word 0x514 selects the fabric to interface clock ratio.
// - Word 0x518 selects fabric PLL delay values.
// - Word 0x51C is the subsystem soft reset.
// - Word 0x520 holds the I/O calibration configuration.
// - Word 0x528 selects AXI or AHB-Lite for the fabric master port.
// - With AHB-Lite, the fabric master starts only after configuration; this block only registers ahb_sel and holds nothing off.
// - Word 0x52C enables automatic calibration lock.
// - Words 0x530 and 0x534 report fabric PLL lock status, read only.
// - Word 0x544 reports I/O calibration status, read only.
// - Word 0x548 drives reset of the alignment test circuit.
// - Post-divider code 0..5 decodes to divide by 1, 2, 4, 8, 16, 32.
// - Bypass powers the core down, passes reference, and overrides PLL reset.
//
// Purpose: Wishbone slave for the memory subsystem configuration space
// Assumes: All inputs synchronous to ref_clk; region agents answer on fwd_ack
// Notes:   System group answers one cycle after the request is taken
`timescale 1ns/100ps
module dsc_config_regs (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [10:0]          wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output      logic [31:0]          wb_dat_o,
  output      logic                 wb_ack_o,
  output      dsc_pkg::dsc_fwd_req_t fwd_req,
  input  wire logic                 fwd_ack,
  input  wire logic [31:0]          fwd_rdata,
  input  wire logic                 pll_lock,
  input  wire logic                 cal_done,
  input  wire logic                 cal_error,
  output      dsc_pkg::dsc_pll_cfg_t pll_cfg,
  output      logic [7:0]           pll_delay_sel,
  output      logic                 ctrl_clk_en,
  output      logic [1:0]           standby_mux_sel,
  output      logic [2:0]           clk_ratio_sel,
  output      logic                 subsys_rst_n,
  output      logic [31:0]          iocal_cfg,
  output      logic                 ahb_sel,
  output      logic                 auto_cal_lock_en,
  output      logic                 align_test_rst,
  output      logic [2:0]           irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic in_range(input logic [10:0] a, input logic [10:0] lo,
                                    input logic [10:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [5:0] post_div_decode(input logic [2:0] code);
    case (code)
      3'h0:    post_div_decode = 6'h01;
      3'h1:    post_div_decode = 6'h02;
      3'h2:    post_div_decode = 6'h04;
      3'h3:    post_div_decode = 6'h08;
      3'h4:    post_div_decode = 6'h10;
      3'h5:    post_div_decode = 6'h20;
      default: post_div_decode = 6'h00;
    endcase
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  logic [10:0]          adr_w;
  dsc_pkg::dsc_region_t region;
  dsc_pkg::dsc_state_t  state_reg;
  dsc_pkg::dsc_state_t  state_next;
  logic                 ack_reg;
  logic                 take;
  logic                 take_sys;
  logic                 take_rsv;
  logic                 take_fwd;
  logic                 sys_wr;
  logic                 sys_rd;
  logic                 fwd_done;

  // Low two address bits are dropped: every register is one aligned word
  assign adr_w = {wb_adr_i[10:2], 2'h0};

  assign region = in_range(adr_w, dsc_pkg::CTRL_LO, dsc_pkg::CTRL_HI) ? dsc_pkg::RGN_CTRL :
                  in_range(adr_w, dsc_pkg::PHY_LO, dsc_pkg::PHY_HI)   ? dsc_pkg::RGN_PHY  :
                  in_range(adr_w, dsc_pkg::FIC_LO, dsc_pkg::FIC_HI)   ? dsc_pkg::RGN_FIC  :
                  in_range(adr_w, dsc_pkg::SYS_LO, dsc_pkg::SYS_HI)   ? dsc_pkg::RGN_SYS  :
                  dsc_pkg::RGN_RSV;

  assign take     = ce && wb_cyc_i && wb_stb_i && !ack_reg && (state_reg == dsc_pkg::ST_IDLE);
  assign take_sys = take && (region == dsc_pkg::RGN_SYS);
  assign take_rsv = take && (region == dsc_pkg::RGN_RSV);
  assign take_fwd = take && !take_sys && !take_rsv;
  assign sys_wr   = take_sys && wb_we_i;
  assign sys_rd   = take_sys && !wb_we_i;
  assign fwd_done = (state_reg == dsc_pkg::ST_FWD) && fwd_ack;

  // ****************************************
  // Write lock
  // ****************************************
  logic lock_reg;
  logic lock_next;
  logic lock_hit;

  // The lock word stays writable so software can unlock
  assign lock_hit  = sys_wr && (adr_w == dsc_pkg::OFS_WR_LOCK) && wb_sel_i[0];
  assign lock_next = lock_hit ? wb_dat_i[0] : lock_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else if (ce) begin
      lock_reg <= lock_next;
    end
  end

  // ****************************************
  // Read-write words
  // ****************************************
  logic [31:0] rw_q [dsc_pkg::NUM_RW];
  logic [dsc_pkg::NUM_RW-1:0] rw_wr;

  genvar gi;
  generate
    for (gi = 0; gi < dsc_pkg::NUM_RW; gi++) begin : g_rw
      // Only table entries decode: read-only words take no write
      assign rw_wr[gi] = sys_wr && !lock_reg && (adr_w == dsc_pkg::RW_OFS[gi]);
      dsc_rw_reg #(
        .RESET_VAL (dsc_pkg::RW_RST[gi]),
        .MASK      (dsc_pkg::RW_MASK[gi])
      ) u_word (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .wr_en   (rw_wr[gi]),
        .sel     (wb_sel_i),
        .wdata   (wb_dat_i),
        .q       (rw_q[gi])
      );
    end
  endgenerate

  // ****************************************
  // Status capture
  // ****************************************
  logic pll_lock_q_reg;
  logic lock_lost_reg;
  logic cal_done_seen_reg;
  logic cal_err_seen_reg;
  logic lock_lost_next;
  logic cal_done_next;
  logic cal_err_next;
  logic rd_lock_b;
  logic rd_iocal;
  logic [2:0] int_stat;

  assign rd_lock_b = sys_rd && (adr_w == dsc_pkg::OFS_LOCK_B);
  assign rd_iocal  = sys_rd && (adr_w == dsc_pkg::OFS_IOCAL_ST);

  // Set beats clear-on-read so an event in the reading cycle is kept
  assign lock_lost_next = (pll_lock_q_reg && !pll_lock) || (lock_lost_reg && !rd_lock_b);
  assign cal_done_next  = cal_done || (cal_done_seen_reg && !rd_iocal);
  assign cal_err_next   = cal_error || (cal_err_seen_reg && !rd_iocal);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_lock_q_reg    <= 1'b0;
      lock_lost_reg     <= 1'b0;
      cal_done_seen_reg <= 1'b0;
      cal_err_seen_reg  <= 1'b0;
    end else if (ce) begin
      pll_lock_q_reg    <= pll_lock;
      lock_lost_reg     <= lock_lost_next;
      cal_done_seen_reg <= cal_done_next;
      cal_err_seen_reg  <= cal_err_next;
    end
  end

  assign int_stat = {cal_err_seen_reg, cal_done_seen_reg, lock_lost_reg};

  // ****************************************
  // Read selection
  // ****************************************
  logic [31:0] rw_rd;
  logic [31:0] ro_rd;
  logic [31:0] sys_rd_word;

  always_comb begin
    rw_rd = 32'h0000_0000;
    for (int i = 0; i < dsc_pkg::NUM_RW; i++) begin
      if (adr_w == dsc_pkg::RW_OFS[i]) begin
        rw_rd = rw_q[i];
      end
    end
  end

  assign ro_rd = (adr_w == dsc_pkg::OFS_LOCK_A)   ? {31'h0000_0000, pll_lock_q_reg} :
                 (adr_w == dsc_pkg::OFS_LOCK_B)   ? {31'h0000_0000, lock_lost_reg}  :
                 (adr_w == dsc_pkg::OFS_INT_STAT) ? {29'h0000_0000, int_stat}       :
                 (adr_w == dsc_pkg::OFS_IOCAL_ST) ? {30'h0000_0000, cal_err_seen_reg,
                                                     cal_done_seen_reg} :
                 (adr_w == dsc_pkg::OFS_WR_LOCK)  ? {31'h0000_0000, lock_reg} : 32'h0000_0000;

  assign sys_rd_word = rw_rd | ro_rd;

  // ****************************************
  // Bus sequencing
  // ****************************************
  logic [31:0]           dat_next;
  dsc_pkg::dsc_fwd_req_t fwd_next;

  assign state_next = take_fwd ? dsc_pkg::ST_FWD :
                      fwd_done ? dsc_pkg::ST_IDLE : state_reg;

  // Reserved space answers with zero and drops writes
  assign dat_next = take_sys ? (wb_we_i ? 32'h0000_0000 : sys_rd_word) :
                    fwd_done ? fwd_rdata : 32'h0000_0000;

  // Forwarded regions: the request stands until the region agent acks
  always_comb begin
    fwd_next = fwd_req;
    case (state_reg)
      dsc_pkg::ST_IDLE: begin
        if (take_fwd) begin
          fwd_next.valid  = 1'b1;
          fwd_next.region = region;
          fwd_next.addr   = adr_w;
          fwd_next.we     = wb_we_i;
          fwd_next.sel    = wb_sel_i;
          fwd_next.wdata  = wb_dat_i;
        end
      end
      dsc_pkg::ST_FWD: begin
        if (fwd_ack) begin
          fwd_next.valid = 1'b0;
        end
      end
      default: begin
        fwd_next.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= dsc_pkg::ST_IDLE;
      ack_reg   <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      fwd_req   <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      ack_reg   <= take_sys || take_rsv || fwd_done;
      wb_dat_o  <= dat_next;
      fwd_req   <= fwd_next;
    end
  end

  assign wb_ack_o = ack_reg;

  // ****************************************
  // Configuration outputs
  // ****************************************
  logic [31:0]           pll_a;
  logic [31:0]           pll_b;
  logic [31:0]           pll_h;
  dsc_pkg::dsc_pll_cfg_t pll_next;
  logic [2:0]            irq_next;

  assign pll_a = rw_q[dsc_pkg::IX_PLL_A];
  assign pll_b = rw_q[dsc_pkg::IX_PLL_B];
  assign pll_h = rw_q[dsc_pkg::IX_PLL_HIGH];

  assign pll_next.ref_div        = pll_a[dsc_pkg::REF_DIV_LSB +: 6];
  assign pll_next.fb_div         = pll_a[dsc_pkg::FB_DIV_LSB +: 10];
  assign pll_next.post_div_ratio = post_div_decode(pll_b[dsc_pkg::POST_DIV_LSB +: 3]);
  // Power-down dominates bypass, then bypass dominates reset
  assign pll_next.power_down = pll_h[dsc_pkg::PD_BIT] | pll_h[dsc_pkg::BYPASS_BIT];
  assign pll_next.bypass     = pll_h[dsc_pkg::BYPASS_BIT] & ~pll_h[dsc_pkg::PD_BIT];
  assign pll_next.reset      = pll_b[dsc_pkg::PLL_RST_BIT] & ~pll_h[dsc_pkg::BYPASS_BIT];
  assign pll_next.fse        = pll_h[dsc_pkg::FSE_BIT];
  assign pll_next.mode_3v3   = pll_h[dsc_pkg::MODE_3V3_BIT];
  assign pll_next.mode_1v2   = pll_h[dsc_pkg::MODE_1V2_BIT];

  assign irq_next = int_stat & rw_q[dsc_pkg::IX_INT_EN][2:0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_cfg          <= '0;
      pll_delay_sel    <= 8'h00;
      ctrl_clk_en      <= 1'b0;
      standby_mux_sel  <= 2'h0;
      clk_ratio_sel    <= 3'h0;
      subsys_rst_n     <= 1'b0;
      iocal_cfg        <= 32'h0000_0000;
      ahb_sel          <= 1'b0;
      auto_cal_lock_en <= 1'b0;
      align_test_rst   <= 1'b1;
      irq              <= 3'h0;
    end else if (ce) begin
      pll_cfg          <= pll_next;
      pll_delay_sel    <= rw_q[dsc_pkg::IX_DELAY][7:0];
      ctrl_clk_en      <= rw_q[dsc_pkg::IX_CLK_EN][0];
      standby_mux_sel  <= rw_q[dsc_pkg::IX_STBY_MUX][1:0];
      clk_ratio_sel    <= rw_q[dsc_pkg::IX_RATIO][2:0];
      subsys_rst_n     <= ~rw_q[dsc_pkg::IX_SOFT_RST][0];
      iocal_cfg        <= rw_q[dsc_pkg::IX_IOCAL_CFG];
      // Bus type bit 0 selects AHB-Lite; no fabric master start hold-off is applied here
      ahb_sel          <= rw_q[dsc_pkg::IX_BUS_TYPE][0];
      auto_cal_lock_en <= rw_q[dsc_pkg::IX_AUTO_LOCK][0];
      align_test_rst   <= rw_q[dsc_pkg::IX_ALIGN_RST][0];
      irq              <= irq_next;
    end
  end

endmodule

// File: dsc_fwd_agent.sv
// Purpose: Region agent answering forwarded requests late
// Assumes: One forwarded request at a time
// Notes:   Read data toggles outside the answer to expose stale data
`timescale 1ns/100ps
module dsc_fwd_agent (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire dsc_pkg::dsc_fwd_req_t fwd_req,
  input wire logic [3:0]            dly,
  output     logic                  fwd_ack,
  output     logic [31:0]           fwd_rdata
);
  logic [3:0] cnt_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg   <= 4'h0;
      fwd_ack   <= 1'b0;
      fwd_rdata <= 32'h0000_0000;
    end else begin
      fwd_ack   <= 1'b0;
      fwd_rdata <= ~fwd_rdata;
      if (fwd_req.valid && !fwd_ack) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg >= dly) begin
          cnt_reg   <= 4'h0;
          fwd_ack   <= 1'b1;
          fwd_rdata <= {21'h0, fwd_req.addr} ^ 32'hC3C3_0000;
        end
      end
    end
  end
endmodule

// File: dsc_pkg.sv
// Purpose: Constants and types of the configuration bank
// Assumes: 2 KB byte-offset space, 32-bit Wishbone data, word-aligned registers
// Notes:   Offsets are byte offsets inside the subsystem register space
package dsc_pkg;

  // ****************************************
  // Bus geometry and region map
  // ****************************************
  localparam int ADDR_W = 11;
  localparam int DATA_W = 32;

  localparam logic [10:0] CTRL_LO = 11'h000;
  localparam logic [10:0] CTRL_HI = 11'h1FC;
  localparam logic [10:0] PHY_LO  = 11'h200;
  localparam logic [10:0] PHY_HI  = 11'h3FC;
  localparam logic [10:0] FIC_LO  = 11'h400;
  localparam logic [10:0] FIC_HI  = 11'h4FC;
  localparam logic [10:0] SYS_LO  = 11'h500;
  localparam logic [10:0] SYS_HI  = 11'h5FC;
  localparam logic [10:0] RSV_LO  = 11'h600;
  localparam logic [10:0] RSV_HI  = 11'h7FC;

  typedef enum logic [2:0] {
    RGN_CTRL = 3'h0,
    RGN_PHY  = 3'h1,
    RGN_FIC  = 3'h2,
    RGN_SYS  = 3'h3,
    RGN_RSV  = 3'h4
  } dsc_region_t;

  // ****************************************
  // System register group offsets
  // ****************************************
  localparam logic [10:0] OFS_PLL_A     = 11'h500;
  localparam logic [10:0] OFS_PLL_B     = 11'h504;
  localparam logic [10:0] OFS_PLL_HIGH  = 11'h508;
  localparam logic [10:0] OFS_CLK_EN    = 11'h50C;
  localparam logic [10:0] OFS_STBY_MUX  = 11'h510;
  localparam logic [10:0] OFS_RATIO     = 11'h514;
  localparam logic [10:0] OFS_DELAY     = 11'h518;
  localparam logic [10:0] OFS_SOFT_RST  = 11'h51C;
  localparam logic [10:0] OFS_IOCAL_CFG = 11'h520;
  localparam logic [10:0] OFS_INT_EN    = 11'h524;
  localparam logic [10:0] OFS_BUS_TYPE  = 11'h528;
  localparam logic [10:0] OFS_AUTO_LOCK = 11'h52C;
  localparam logic [10:0] OFS_LOCK_A    = 11'h530;
  localparam logic [10:0] OFS_LOCK_B    = 11'h534;
  localparam logic [10:0] OFS_INT_STAT  = 11'h53C;
  localparam logic [10:0] OFS_IOCAL_ST  = 11'h544;
  localparam logic [10:0] OFS_ALIGN_RST = 11'h548;
  localparam logic [10:0] OFS_WR_LOCK   = 11'h5F8;

  // ****************************************
  // Read-write register table
  // ****************************************
  localparam int NUM_RW = 13;
  localparam int IX_PLL_A = 0;
  localparam int IX_PLL_B = 1;
  localparam int IX_PLL_HIGH = 2;
  localparam int IX_CLK_EN = 3;
  localparam int IX_STBY_MUX = 4;
  localparam int IX_RATIO = 5;
  localparam int IX_DELAY = 6;
  localparam int IX_SOFT_RST = 7;
  localparam int IX_IOCAL_CFG = 8;
  localparam int IX_INT_EN = 9;
  localparam int IX_BUS_TYPE = 10;
  localparam int IX_AUTO_LOCK = 11;
  localparam int IX_ALIGN_RST = 12;

  localparam logic [10:0] RW_OFS [NUM_RW] = '{
    OFS_PLL_A, OFS_PLL_B, OFS_PLL_HIGH, OFS_CLK_EN, OFS_STBY_MUX, OFS_RATIO,
    OFS_DELAY, OFS_SOFT_RST, OFS_IOCAL_CFG, OFS_INT_EN, OFS_BUS_TYPE,
    OFS_AUTO_LOCK, OFS_ALIGN_RST};
  localparam logic [31:0] RW_RST [NUM_RW] = '{
    32'h0000_0081, 32'h0000_000A, 32'h0000_3800, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0001};
  localparam logic [31:0] RW_MASK [NUM_RW] = '{
    32'h0000_FFFF, 32'h0000_000F, 32'h0000_FFFF, 32'h0000_0001, 32'h0000_0003,
    32'h0000_0007, 32'h0000_00FF, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0007,
    32'h0000_0001, 32'h0000_0001, 32'h0000_0001};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int REF_DIV_LSB = 0;
  localparam int FB_DIV_LSB = 6;
  localparam int POST_DIV_LSB = 0;
  localparam int PLL_RST_BIT = 3;
  localparam int BYPASS_BIT = 11;
  localparam int MODE_1V2_BIT = 12;
  localparam int MODE_3V3_BIT = 13;
  localparam int FSE_BIT = 14;
  localparam int PD_BIT = 15;
  localparam int NUM_IRQ = 3;

  // ****************************************
  // Carried groups and states
  // ****************************************
  typedef struct packed {
    logic [5:0] ref_div;
    logic [9:0] fb_div;
    logic [5:0] post_div_ratio;
    logic       reset;
    logic       power_down;
    logic       bypass;
    logic       fse;
    logic       mode_3v3;
    logic       mode_1v2;
  } dsc_pll_cfg_t;

  typedef struct packed {
    logic        valid;
    dsc_region_t region;
    logic [10:0] addr;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] wdata;
  } dsc_fwd_req_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_FWD  = 1'b1
  } dsc_state_t;

endpackage

// File: dsc_rw_reg.sv
// Purpose: One read-write configuration word with byte enables
// Assumes: Caller has already qualified the write with decode and lock
// Notes:   Bits outside the mask never store and read as zero
`timescale 1ns/100ps
module dsc_rw_reg #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] MASK      = 32'hFFFF_FFFF
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        wr_en,
  input  wire logic [3:0]  sel,
  input  wire logic [31:0] wdata,
  output      logic [31:0] q
);

  logic [31:0] lane_mask;
  logic [31:0] q_next;

  assign lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & MASK;
  assign q_next    = (q & ~lane_mask) | (wdata & lane_mask);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL & MASK;
    end else if (ce && wr_en) begin
      q <= q_next;
    end
  end

endmodule

// File: testbench.sv
// Purpose: Self-checking bench of the configuration bank
// Assumes: Wishbone classic master, one access at a time
// Notes:   Reads queue expectations; the ack watcher compares
`timescale 1ns/100ps
module testbench;
  logic rst_n = 1'b0, ce = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic pll_lock = 1'b1, cal_done = 1'b0, cal_error = 1'b0, ref_clk;
  logic [10:0] wb_adr_i = 11'h000;
  logic [3:0]  wb_sel_i = 4'h0, dly = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic wb_ack_o, fwd_ack, ctrl_clk_en, subsys_rst_n, ahb_sel, auto_cal_lock_en, align_test_rst;
  logic [31:0] wb_dat_o, fwd_rdata, iocal_cfg;
  logic [7:0]  pll_delay_sel;
  logic [1:0]  standby_mux_sel;
  logic [2:0]  clk_ratio_sel, irq;
  dsc_pkg::dsc_fwd_req_t fwd_req;
  dsc_pkg::dsc_pll_cfg_t pll_cfg;
  logic [31:0] exp_q[$];
  logic [31:0] v [dsc_pkg::NUM_RW];
  int n_mismatch = 0;
  int checks = 0;
  int seed = 58;
  localparam logic [10:0] FWD_A [6] = '{11'h000, 11'h1FC, 11'h200, 11'h3FC, 11'h400, 11'h4FC};
  localparam logic [10:0] RO_A [7] = '{11'h530, 11'h534, 11'h53C, 11'h544, 11'h540, 11'h600,
                                       11'h7FC};
  dsc_config_regs i_dut (.ref_clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fwd_req, .fwd_ack, .fwd_rdata, .pll_lock,
    .cal_done, .cal_error, .pll_cfg, .pll_delay_sel, .ctrl_clk_en, .standby_mux_sel,
    .clk_ratio_sel, .subsys_rst_n, .iocal_cfg, .ahb_sel, .auto_cal_lock_en, .align_test_rst,
    .irq);
  dsc_fwd_agent i_agent (.ref_clk, .rst_n, .fwd_req, .dly, .fwd_ack, .fwd_rdata);
  // ****************************************
  // Compare, bus and closing tasks
  // ****************************************
  task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    cmp_out(got, exp);
  endtask
  // Starts after a rising edge; waits for ack
  task automatic wb(input logic [10:0] a, input logic we, input logic [3:0] s,
                    input logic [31:0] d, input logic [31:0] e);
    int n = 0;
    if (!we) exp_q.push_back(e);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_mismatch++;
      end_sim;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    wb(a, 1'b1, 4'hF, d, 32'h0000_0000);
  endtask
  task automatic rd(input logic [10:0] a, input logic [31:0] e);
    wb(a, 1'b0, 4'hF, 32'h0000_0000, e);
  endtask
  task automatic end_sim;
    $display("checks=%0d bad=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0)
      cmp_rd(wb_dat_o, exp_q.size() ? exp_q.pop_front() : ~wb_dat_o);
  initial begin
    #100us;
    n_mismatch++;
    end_sim;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d, m;
    logic [3:0]  s;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (v[i]) begin
      rd(dsc_pkg::RW_OFS[i], dsc_pkg::RW_RST[i]);
      d = $random(seed);
      s = 4'($random(seed));
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      v[i] = ((dsc_pkg::RW_RST[i] & ~m) | (d & m)) & dsc_pkg::RW_MASK[i];
      wb(dsc_pkg::RW_OFS[i], 1'b1, s, d, 32'h0000_0000);
      rd(dsc_pkg::RW_OFS[i], v[i]);
    end
    cmp_out(32'({pll_cfg.fb_div, pll_cfg.ref_div}), v[0] & 32'h0000_FFFF);
    cmp_out(32'(ctrl_clk_en), v[3]);
    cmp_out(32'(standby_mux_sel), v[4]);
    cmp_out(32'(clk_ratio_sel), v[5]);
    cmp_out(32'(pll_delay_sel), v[6]);
    cmp_out(32'(!subsys_rst_n), v[7]);
    cmp_out(iocal_cfg, v[8]);
    cmp_out(32'(ahb_sel), v[10]);
    cmp_out(32'(auto_cal_lock_en), v[11]);
    cmp_out(32'(align_test_rst), v[12]);
    $display("test map done");
    foreach (RO_A[i]) begin
      wr(RO_A[i], 32'hFFFF_FFFF);
      rd(RO_A[i], 32'(RO_A[i] == 11'h530));
    end
    $display("test ro done");
    wr(dsc_pkg::OFS_WR_LOCK, 32'h0000_0001);
    wr(dsc_pkg::OFS_RATIO, ~v[5]);
    wr(dsc_pkg::OFS_CLK_EN, ~v[3]);
    rd(dsc_pkg::OFS_RATIO, v[5]);
    rd(dsc_pkg::OFS_CLK_EN, v[3]);
    wr(dsc_pkg::OFS_WR_LOCK, 32'h0000_0000);
    wr(dsc_pkg::OFS_RATIO, 32'h0000_0005);
    rd(dsc_pkg::OFS_RATIO, 32'h0000_0005);
    $display("test lock done");
    foreach (FWD_A[i]) begin
      dly <= 4'($random(seed));
      rd(FWD_A[i], {21'h0, FWD_A[i]} ^ 32'hC3C3_0000);
    end
    $display("test fwd done");
    pll_lock <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(dsc_pkg::OFS_LOCK_B, 32'h0000_0001);
    rd(dsc_pkg::OFS_LOCK_A, 32'h0000_0000);
    rd(dsc_pkg::OFS_LOCK_B, 32'h0000_0000);
    wr(dsc_pkg::OFS_INT_EN, 32'h0000_0002);
    cal_done <= 1'b1;
    cal_error <= 1'b1;
    @(posedge ref_clk);
    cal_done <= 1'b0;
    cal_error <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cmp_out(32'(irq), 32'h0000_0002);
    rd(dsc_pkg::OFS_INT_STAT, 32'h0000_0006);
    rd(dsc_pkg::OFS_IOCAL_ST, 32'h0000_0003);
    repeat (2) @(posedge ref_clk);
    cmp_out(32'(irq), 32'h0000_0000);
    $display("test status done");
    wr(dsc_pkg::OFS_PLL_HIGH, 32'h0000_3000);
    for (int i = 0; i < 6; i++) begin
      wr(dsc_pkg::OFS_PLL_B, 32'h0000_0008 | 32'(i));
      cmp_out(32'({pll_cfg.post_div_ratio, pll_cfg.reset}), 32'((1 << i) * 2 + 1));
    end
    wr(dsc_pkg::OFS_PLL_HIGH, 32'h0000_3800);
    cmp_out(32'({pll_cfg.bypass, pll_cfg.reset, pll_cfg.power_down}), 32'h0000_0005);
    $display("test pll done");
    end_sim;
  end
endmodule
